// ==== pkg/status_id_regs.svh ====
// register offsets, field positions, the status reset value, used-bit masks and the frame bit count for the status and id bank
`ifndef STATUS_ID_REGS_SVH
`define STATUS_ID_REGS_SVH
`define OFS_ERROR_FLAG_STATUS 7'h26
`define OFS_LOT_CODE_WORD_1   7'h32
`define OFS_LOT_CODE_WORD_2   7'h34
`define OFS_LOT_CODE_WORD_3   7'h36
`define OFS_PRODUCT_CODE_WORD 7'h38
`define OFS_UNIT_SERIAL_WORD  7'h3a
`define BIT_ALARM2            9
`define BIT_ALARM1            8
`define BIT_CHECKSUM          6
`define BIT_SELFTEST          5
`define BIT_OVERRANGE         4
`define BIT_LINKERR           3
`define BIT_FLASHFAIL         2
`define STATUS_RESET          16'h0000
`define STATUS_USED_MASK      16'h037c
`define SERIAL_USED_MASK      16'h3fff
`define FRAME_BITS            5'd16
`endif

// ==== pkg/status_id_pkg.sv ====
// types shared by the status and id bank
package status_id_pkg;
  typedef struct packed {
    logic alarm2;
    logic alarm1;
    logic checksumFail;
    logic selfTestFail;
    logic overRange;
    logic flashFail;
  } err_cond_t;

  typedef struct packed {
    logic [15:0] productCode;
    logic [15:0] lot1;
    logic [15:0] lot2;
    logic [15:0] lot3;
    logic [15:0] serial;
  } id_words_t;
endpackage : status_id_pkg

// ==== hw/pin_sync.sv ====
// two-flop synchroniser for a group of pins
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);
  logic [W-1:0] stage1Reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1Reg <= '0;
      pinSync   <= '0;
    end else if (clkEn) begin
      stage1Reg <= pinIn;
      pinSync   <= stage1Reg;
    end
  end
endmodule : pin_sync

// ==== hw/frame_counter.sv ====
// counts serial clock rising edges per chip-select frame and checks for whole 16-bit words
module frame_counter (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic sclkRise,
  input  wire logic frameStart,
  input  wire logic frameEnd,
  output logic      badFrame
);
  `include "status_id_regs.svh"
  logic [3:0] modReg;
  logic [3:0] modNext;
  wire        wrap = (modReg == 4'(`FRAME_BITS - 5'd1));

  assign modNext = frameStart ? 4'h0 : (sclkRise ? (wrap ? 4'h0 : modReg + 4'h1) : modReg);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      modReg   <= 4'h0;
      badFrame <= 1'b0;
    end else if (clkEn) begin
      modReg   <= modNext;
      badFrame <= frameEnd && (modReg != 4'h0); // [RULE4]
    end
  end
endmodule : frame_counter

// ==== hw/status_id_registers.sv ====
// status flags and identification words read over the serial port
// How it works
// [RULE1] flags read one on error, zero normal
// [RULE2] status read returns flags then clears them
// [RULE3] persisting conditions set again next sample cycle
// [RULE4] bit 3 flags frames not multiple of 16
// [RULE5] bits 9 and 8 mirror alarms 2, 1
// [RULE6] bit 6 shows checksum failure
// [RULE7] bit 5 shows self-test failure
// [RULE8] bit 4 shows rate overrange
// [RULE9] bit 2 shows flash update failure
// [RULE10] status is zero after reset
// [RULE11] product word is a fixed code
// [RULE12] three lot words return fixed codes
// [RULE13] serial in low fourteen bits
// [RULE14] unused bits read zero, writes ignored
module status_id_registers
  import status_id_pkg::*;
#(
  // arbitrary neutral identity values
  parameter logic [15:0] PRODUCT_CODE = 16'h1234,
  parameter logic [15:0] LOT_CODE_1   = 16'h0001,
  parameter logic [15:0] LOT_CODE_2   = 16'h0002,
  parameter logic [15:0] LOT_CODE_3   = 16'h0003,
  parameter logic [13:0] SERIAL_CODE  = 14'h0001
) (
  input  wire logic      clock,
  input  wire logic      rst_n,
  input  wire logic      clkEn,
  input  wire logic      csPin_n,
  input  wire logic      sclkPin,
  input  wire logic      dinPin,
  output logic           doutPin,
  output logic           doutOe,
  input  wire logic      sampleDone,
  input  wire err_cond_t errCond
);
  `include "status_id_regs.svh"

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } link_state_t;

  // pins come from the host's clock domain
  logic [2:0] pinS;
  pin_sync #(.W(3)) uSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .pinIn   ({csPin_n, sclkPin, dinPin}),
    .pinSync (pinS)
  );
  wire csS_n = pinS[2];
  wire sclkS = pinS[1];
  wire dinS  = pinS[0];

  logic        sclkPrev;
  logic        csPrev_n;
  link_state_t state_reg;
  link_state_t state_next;
  logic [15:0] shift_reg;
  logic [3:0]  bitCnt_reg;
  logic [6:0]  addr_reg;
  logic [15:0] txWord_reg;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic        readStatus;
  logic        badFrame;

  wire sclkRise   = sclkS && !sclkPrev;
  wire frameStart = csPrev_n && !csS_n;
  wire frameEnd   = !csPrev_n && csS_n;
  wire wordDone   = (state_reg == ST_FRAME) && sclkRise && (bitCnt_reg == 4'hf);
  wire [15:0] rxWord = {shift_reg[14:0], dinS};
  // bit 15 of a command word marks a write; writes find no writable field here
  wire cmdRead = wordDone && !rxWord[15];

  function automatic logic [15:0] regRead(input logic [6:0] a, input logic [15:0] st);
    unique case (a)
      `OFS_ERROR_FLAG_STATUS: regRead = st & `STATUS_USED_MASK; // [RULE14]
      `OFS_PRODUCT_CODE_WORD: regRead = PRODUCT_CODE; // [RULE11]
      `OFS_LOT_CODE_WORD_1:   regRead = LOT_CODE_1; // [RULE12]
      `OFS_LOT_CODE_WORD_2:   regRead = LOT_CODE_2; // [RULE12]
      `OFS_LOT_CODE_WORD_3:   regRead = LOT_CODE_3; // [RULE12]
      `OFS_UNIT_SERIAL_WORD:  regRead = {2'b00, SERIAL_CODE} & `SERIAL_USED_MASK; // [RULE13]
      default:                regRead = 16'h0000;
    endcase
  endfunction : regRead

  // reply word is latched when the next word starts, so the clear must follow that latch
  wire loadTx = wordDone;
  wire [15:0] txNext = regRead(addr_reg, status_reg);
  assign readStatus = loadTx && (addr_reg == `OFS_ERROR_FLAG_STATUS);

  // conditions are sampled at each sample cycle end; alarms and others latch sticky
  wire [15:0] condVec = ({15'h0, errCond.alarm2}       << `BIT_ALARM2)    // [RULE5]
                      | ({15'h0, errCond.alarm1}       << `BIT_ALARM1)    // [RULE5]
                      | ({15'h0, errCond.checksumFail} << `BIT_CHECKSUM)  // [RULE6]
                      | ({15'h0, errCond.selfTestFail} << `BIT_SELFTEST)  // [RULE7]
                      | ({15'h0, errCond.overRange}    << `BIT_OVERRANGE) // [RULE8]
                      | ({15'h0, errCond.flashFail}    << `BIT_FLASHFAIL); // [RULE9]
  wire [15:0] linkVec = {15'h0, badFrame} << `BIT_LINKERR; // [RULE4]
  wire [15:0] setVec  = ((sampleDone ? condVec : 16'h0) | linkVec) & `STATUS_USED_MASK; // [RULE1]

  // set wins over the clear so an event in the read cycle is kept
  assign status_next = (readStatus ? 16'h0000 : status_reg) | setVec; // [RULE2] [RULE3]

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (frameStart) state_next = ST_FRAME;
      ST_FRAME: if (frameEnd) state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclkPrev    <= 1'b0;
      csPrev_n    <= 1'b1;
      state_reg   <= ST_IDLE;
      shift_reg   <= 16'h0000;
      bitCnt_reg  <= 4'h0;
      addr_reg    <= 7'h00;
      txWord_reg  <= 16'h0000;
      status_reg  <= `STATUS_RESET; // [RULE10]
      doutPin     <= 1'b0;
      doutOe      <= 1'b0;
    end else if (clkEn) begin
      sclkPrev    <= sclkS;
      csPrev_n    <= csS_n;
      state_reg   <= state_next;
      status_reg  <= status_next;
      if (frameStart) begin
        bitCnt_reg <= 4'h0;
      end else if ((state_reg == ST_FRAME) && sclkRise) begin
        shift_reg  <= rxWord;
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
      // a stale address from the last frame must not clear the flags at the first word
      if (frameStart) begin
        addr_reg <= 7'h00;
      end else if (cmdRead) begin
        addr_reg <= {rxWord[13:8], 1'b0};
      end
      if (loadTx) begin
        txWord_reg <= txNext;
      end else if ((state_reg == ST_FRAME) && sclkRise) begin
        // shift after the host has sampled, so the msb stands for the whole first bit
        txWord_reg <= {txWord_reg[14:0], 1'b0};
      end
      doutOe  <= !csS_n;
      doutPin <= txWord_reg[15];
    end
  end

  frame_counter uFrame (
    .clock      (clock),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .sclkRise   (sclkRise && (state_reg == ST_FRAME)),
    .frameStart (frameStart),
    .frameEnd   (frameEnd),
    .badFrame   (badFrame)
  );
endmodule : status_id_registers

// ==== test/spi_host_model.sv ====
// serial host that frames bits with chip select and a slow link clock
module spi_host_model (
  input  wire logic clock,
  output logic      csPin_n,
  output logic      sclkPin,
  output logic      dinPin,
  input  wire logic doutPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    csPin_n = 1'b1;
    sclkPin = 1'b1;
    dinPin  = 1'b0;
  end
  // n link edges, msb first from tx[n-1]; eight system clocks per link period
  task automatic frame(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    @(posedge clock) csPin_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = n - 1; i >= 0; i--) begin
      sclkPin <= 1'b0;
      dinPin  <= tx[i];
      repeat (4) @(posedge clock);
      sclkPin <= 1'b1;
      repeat (3) @(posedge clock);
      rx[i] = doutPin;
      @(posedge clock);
    end
    csPin_n <= 1'b1;
    // released line must not keep showing the last bit
    dinPin  <= ~dinPin;
    repeat (8) @(posedge clock);
  endtask : frame
endmodule : spi_host_model

// ==== test/status_id_registers_sva.sv ====
// pin-level checks for the status and id bank
module status_id_registers_sva
  import status_id_pkg::*;
(
  input wire logic      clock,
  input wire logic      rst_n,
  input wire logic      clkEn,
  input wire logic      csPin_n,
  input wire logic      sclkPin,
  input wire logic      dinPin,
  input wire logic      doutPin,
  input wire logic      doutOe,
  input wire logic      sampleDone,
  input wire err_cond_t errCond
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_idle_a: assert property ($rose(rst_n) |-> !doutPin && !doutOe) else $error("pins busy after reset");
  freeze_dout_a: assert property (!clkEn |=> $stable(doutPin)) else $error("dout moved while frozen");
  freeze_oe_a: assert property (!clkEn |=> $stable(doutOe)) else $error("enable moved while frozen");
  oe_on_a: assert property ($fell(csPin_n) |-> ##[1:5] doutOe) else $error("enable late");
  oe_off_a: assert property ($rose(csPin_n) |-> ##[1:5] !doutOe) else $error("enable stuck");
  oe_idle_a: assert property (csPin_n [*6] |-> !doutOe) else $error("driving while idle");
  oe_busy_a: assert property ((!csPin_n) [*6] |-> doutOe) else $error("silent in frame");
  dout_still_a: assert property (csPin_n [*8] |-> $stable(doutPin)) else $error("dout moved while idle");
endmodule : status_id_registers_sva
bind status_id_registers status_id_registers_sva i_status_id_registers_sva (.clock(clock), .rst_n(rst_n),
  .clkEn(clkEn), .csPin_n(csPin_n), .sclkPin(sclkPin), .dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe),
  .sampleDone(sampleDone), .errCond(errCond));

// ==== test/tb_top.sv ====
// self-checking bench for the status and id bank
module tb_top
  import status_id_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [6:0]  ofs;
    err_cond_t   cond;
    logic [15:0] exp;
  } row_t;
  logic        clock = 1'b0, rst_n = 1'b0, clkEn = 1'b1, sampleDone = 1'b0;
  err_cond_t   errCond = '0;
  logic        csPin_n, sclkPin, dinPin, doutPin, doutOe;
  logic [47:0] rx;
  int          nFail = 0, checksDone = 0;
  row_t        rows [13] = '{'{7'h38, 6'h00, 16'h1234}, '{7'h32, 6'h00, 16'h0001}, '{7'h34, 6'h00, 16'h0002},
    '{7'h36, 6'h00, 16'h0003}, '{7'h3a, 6'h00, 16'h270f}, '{7'h28, 6'h00, 16'h0000}, '{7'h26, 6'h20, 16'h0200},
    '{7'h26, 6'h10, 16'h0100}, '{7'h26, 6'h08, 16'h0040}, '{7'h26, 6'h04, 16'h0020}, '{7'h26, 6'h02, 16'h0010},
    '{7'h26, 6'h01, 16'h0004}, '{7'h26, 6'h3f, 16'h0374}};
  always #10 clock = ~clock;
  // serial word sets bit 13, the top bit of its fourteen, so the upper two bits must still read zero
  status_id_registers #(.SERIAL_CODE(14'h270f)) i_status_id_registers (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
    .csPin_n(csPin_n), .sclkPin(sclkPin), .dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe),
    .sampleDone(sampleDone), .errCond(errCond));
  spi_host_model i_spi_host_model (.clock(clock), .csPin_n(csPin_n), .sclkPin(sclkPin), .dinPin(dinPin),
    .doutPin(doutPin));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // command word, a filler word, then the reply word
  task automatic rd(input logic [6:0] ofs, input logic [15:0] exp);
    i_spi_host_model.frame(48, {2'b00, ofs[6:1], 40'h0}, rx);
    checksDone++;
    if (rx[15:0] !== exp) begin
      nFail++;
      $display("mismatch reg %h expected %h seen %h", ofs, exp, rx[15:0]);
    end
  endtask : rd
  task automatic pulse(input err_cond_t c);
    @(posedge clock) errCond <= c;
    sampleDone <= 1'b1;
    @(posedge clock) sampleDone <= 1'b0;
  endtask : pulse
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(7'h26, 16'h0000);
    foreach (rows[i]) begin
      pulse(rows[i].cond);
      errCond <= '0;
      rd(rows[i].ofs, rows[i].exp);
      rd(7'h26, 16'h0000);
    end
    // condition stays up across the reads: only the next sample may raise it again
    pulse(6'h02);
    rd(7'h26, 16'h0010);
    rd(7'h26, 16'h0000);
    pulse(6'h02);
    errCond <= '0;
    rd(7'h26, 16'h0010);
    i_spi_host_model.frame(17, 48'h0, rx);
    rd(7'h26, 16'h0008);
    i_spi_host_model.frame(16, 48'hbaff, rx);
    rd(7'h3a, 16'h270f);
    i_spi_host_model.frame(16, 48'ha6ff, rx);
    rd(7'h26, 16'h0000);
    @(posedge clock) clkEn <= 1'b0;
    pulse(6'h3f);
    errCond <= '0;
    clkEn <= 1'b1;
    rd(7'h26, 16'h0000);
    pulse(6'h3f);
    errCond <= '0;
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(7'h26, 16'h0000);
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clock);
    nFail++;
    end_of_test();
  end
endmodule : tb_top
